//--- hw/fbm_axil_regs.v
`timescale 1ns/1ps
`include "fbm_defines.vh"
module fbm_axil_regs (
    input wire clk, // System clock
    input wire rst_b, // Async reset, active low
    input wire [7:0] awaddr, // Write address
    input wire awvalid, // Write address valid
    output reg awready, // Write address ready
    input wire [31:0] wdata, // Write data
    input wire [3:0] wstrb, // Write strobes
    input wire wvalid, // Write data valid
    output reg wready, // Write data ready
    output reg [1:0] bresp, // Write response
    output reg bvalid, // Write response valid
    input wire bready, // Write response ready
    input wire [7:0] araddr, // Read address
    input wire arvalid, // Read address valid
    output reg arready, // Read address ready
    output reg [31:0] rdata, // Read data
    output reg [1:0] rresp, // Read response
    output reg rvalid, // Read data valid
    input wire rready, // Read data ready
    output reg [4:0] ctrl_q, // Control bits
    output reg [22:0] addr_q, // Flash address, A-1 in bit 0 for byte mode
    output reg [15:0] wdat_q, // Data for the next write cycle
    output reg cmdGo_q, // One-cycle command pulse
    output reg [1:0] cmdCode_q, // Command with the pulse
    output reg errClr_q, // One-cycle clear of sticky status
    input wire [31:0] statusIn, // Live status word
    input wire [15:0] rdataIn // Last captured read data
);
    reg [7:0] awAddr_q;
    reg [31:0] wData_q;
    reg [3:0] wStrb_q;
    wire awHeld = !awready;
    wire wHeld = !wready;

    // Write side: address and data taken in either order, answered once both are in
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= 2'h0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h00000000;
            wStrb_q <= 4'h0;
            ctrl_q <= `FBM_CTRL_RESET;
            addr_q <= 23'h000000;
            wdat_q <= 16'h0000;
            cmdGo_q <= 1'b0;
            cmdCode_q <= 2'h0;
            errClr_q <= 1'b0;
        end else begin
            cmdGo_q <= 1'b0;
            errClr_q <= 1'b0;
            if (awvalid && awready) begin
                awAddr_q <= awaddr;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                wData_q <= wdata;
                wStrb_q <= wstrb;
                wready <= 1'b0;
            end
            if (awHeld && wHeld && !bvalid) begin
                bvalid <= 1'b1;
                bresp <= 2'h0;
                // Partial strobes are honoured on the low lanes for the narrow fields; the address register needs all four lanes
                if (awAddr_q == `FBM_REG_CTRL) begin
                    if (wStrb_q[0])
                        ctrl_q <= wData_q[4:0];
                end else if (awAddr_q == `FBM_REG_ADDR) begin
                    if (wStrb_q == 4'hf)
                        addr_q <= wData_q[22:0];
                end else if (awAddr_q == `FBM_REG_WDATA) begin
                    if (wStrb_q[1:0] == 2'h3)
                        wdat_q <= wData_q[15:0];
                end else if (awAddr_q == `FBM_REG_CMD) begin
                    cmdGo_q <= wStrb_q[0] && (wData_q[1:0] != 2'h0);
                    cmdCode_q <= wData_q[1:0];
                end else if (awAddr_q == `FBM_REG_STATUS) begin
                    errClr_q <= wStrb_q[0];
                end else if (awAddr_q != `FBM_REG_RDATA) begin
                    bresp <= 2'h2;
                end
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Read side: one cycle from address to data
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= 2'h0;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= 2'h0;
            if (araddr == `FBM_REG_CTRL)
                rdata <= {27'h0000000, ctrl_q};
            else if (araddr == `FBM_REG_ADDR)
                rdata <= {9'h000, addr_q};
            else if (araddr == `FBM_REG_WDATA)
                rdata <= {16'h0000, wdat_q};
            else if (araddr == `FBM_REG_CMD)
                rdata <= 32'h00000000;
            else if (araddr == `FBM_REG_STATUS)
                rdata <= statusIn;
            else if (araddr == `FBM_REG_RDATA)
                rdata <= {16'h0000, rdataIn};
            else begin
                rdata <= 32'h00000000;
                rresp <= 2'h2;
            end
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end
endmodule

//--- hw/fbm_ctrl.v
// Chosen here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fbm_defines.vh"
module fbm_ctrl #(
    parameter ACC_CYC = `FBM_ACC_CYC, // Full random access, cycles
    parameter PACC_CYC = `FBM_PACC_CYC, // Same-page access, cycles
    parameter CE_CYC = `FBM_CE_CYC, // Select access from standby, cycles
    parameter WP_CYC = `FBM_WP_CYC, // Write strobe low time, cycles
    parameter RP_CYC = `FBM_RP_CYC, // Clear pulse width, cycles
    parameter RH_CYC = `FBM_RH_CYC // Recovery after clear, cycles
) (
    input wire clk, // System clock
    input wire rst_b, // Async reset, active low
    input wire [7:0] awaddr, // AXI write address
    input wire awvalid, // AXI write address valid
    output wire awready, // AXI write address ready
    input wire [31:0] wdata, // AXI write data
    input wire [3:0] wstrb, // AXI write strobes
    input wire wvalid, // AXI write data valid
    output wire wready, // AXI write data ready
    output wire [1:0] bresp, // AXI write response
    output wire bvalid, // AXI write response valid
    input wire bready, // AXI write response ready
    input wire [7:0] araddr, // AXI read address
    input wire arvalid, // AXI read address valid
    output wire arready, // AXI read address ready
    output wire [31:0] rdata, // AXI read data
    output wire [1:0] rresp, // AXI read response
    output wire rvalid, // AXI read data valid
    input wire rready, // AXI read data ready
    output reg [21:0] flashAddr_q, // Flash address pins A21..A0
    input wire [15:0] dqIn, // Data pins as seen on the wire
    output reg [15:0] dqOut_q, // Data pin drive values
    output reg [15:0] dqOe_b_q, // Data pin enables, low drives
    output reg selectN_q, // Chip select, active low
    output reg outEnN_q, // Output enable, active low
    output reg writeN_q, // Write strobe, active low
    output reg clearN_q, // Hardware clear, active low
    output reg wordSel_q, // Width select: high word, low byte
    output reg protLevel_q, // Protect pin logic level when not boosted
    output reg boostEn_q // Raise protect_accel_pin to boost_voltage
);
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_READ = 3'h1;
    localparam [2:0] ST_WSETUP = 3'h2;
    localparam [2:0] ST_WPULSE = 3'h3;
    localparam [2:0] ST_WHOLD = 3'h4;
    localparam [2:0] ST_CLEAR = 3'h5;
    localparam [2:0] ST_RECOVER = 3'h6;

    wire [4:0] ctrl;
    wire [22:0] addr;
    wire [15:0] wdat;
    wire cmdGo;
    wire [1:0] cmdCode;
    wire errClr;
    reg [2:0] state_q;
    reg [15:0] cnt_q;
    reg [15:0] rdat_q;
    reg [15:0] dqMeta_q;
    reg [15:0] dqSync_q;
    reg [20:0] lastPage_q;
    reg pageValid_q;
    reg [5:0] bufCnt_q;
    reg refused_q;
    reg bufErr_q;
    wire wordMode = ctrl[`FBM_CTRL_WORD];
    wire boostReq = ctrl[`FBM_CTRL_BOOST];
    wire bufMode = ctrl[`FBM_CTRL_BUF];
    wire [5:0] bufLimit = wordMode ? 6'd`FBM_BUF_WORDS : 6'd`FBM_BUF_BYTES;
    wire bufFull = bufMode && (bufCnt_q >= bufLimit);
    wire busy = (state_q != ST_IDLE);
    wire [31:0] status = {26'h0000000, bufCnt_q[2:0], bufErr_q, refused_q, busy};

    // Page number: word mode drops A1..A0, byte mode drops A1..A-1
    function [20:0] pageOf;
        input [22:0] a;
        input wm;
        begin
            pageOf = wm ? {1'b0, a[21:2]} : {1'b0, a[22:3]};
        end
    endfunction

    // Address pins: byte mode shifts A-1 out onto the data msb line
    function [21:0] pinAddr;
        input [22:0] a;
        input wm;
        begin
            pinAddr = wm ? a[21:0] : a[22:1];
        end
    endfunction

    fbm_axil_regs regs (
        .clk(clk),
        .rst_b(rst_b),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .ctrl_q(ctrl),
        .addr_q(addr),
        .wdat_q(wdat),
        .cmdGo_q(cmdGo),
        .cmdCode_q(cmdCode),
        .errClr_q(errClr),
        .statusIn(status),
        .rdataIn(rdat_q)
    );

    // Data pins come from outside the clock domain
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dqMeta_q <= 16'h0000;
            dqSync_q <= 16'h0000;
        end else begin
            dqMeta_q <= dqIn;
            dqSync_q <= dqMeta_q;
        end
    end

    // Pin sequencer; commands while busy are refused
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            rdat_q <= 16'h0000;
            flashAddr_q <= 22'h000000;
            dqOut_q <= 16'h0000;
            dqOe_b_q <= 16'hffff;
            selectN_q <= 1'b1;
            outEnN_q <= 1'b1;
            writeN_q <= 1'b1;
            clearN_q <= 1'b1;
            wordSel_q <= 1'b1;
            protLevel_q <= 1'b1;
            boostEn_q <= 1'b0;
            lastPage_q <= 21'h000000;
            pageValid_q <= 1'b0;
            bufCnt_q <= 6'h00;
            refused_q <= 1'b0;
            bufErr_q <= 1'b0;
        end else begin
            wordSel_q <= wordMode;
            protLevel_q <= ctrl[`FBM_CTRL_PROT];
            boostEn_q <= boostReq;
            if (!bufMode)
                bufCnt_q <= 6'h00;
            // A set in the same cycle as the clear wins
            if (errClr) begin
                refused_q <= 1'b0;
                bufErr_q <= 1'b0;
            end
            // Byte mode: lines 8-14 float, line 15 carries A-1 whenever selected
            if (!wordMode) begin
                dqOe_b_q[14:8] <= 7'h7f;
                dqOut_q[15] <= addr[0];
                dqOe_b_q[15] <= selectN_q && !busy;
            end
            case (state_q)
                ST_IDLE: begin
                    writeN_q <= 1'b1;
                    outEnN_q <= 1'b1;
                    if (cmdGo && cmdCode == `FBM_CMD_READ && !boostReq) begin
                        flashAddr_q <= pinAddr(addr, wordMode);
                        selectN_q <= 1'b0;
                        outEnN_q <= 1'b0;
                        dqOe_b_q[7:0] <= 8'hff;
                        if (wordMode)
                            dqOe_b_q <= 16'hffff;
                        else begin
                            dqOut_q[15] <= addr[0];
                            dqOe_b_q[15] <= 1'b0;
                        end
                        // Same page with select low gets the short time; +3 covers settle and sync flops
                        if (!selectN_q && pageValid_q && lastPage_q == pageOf(addr, wordMode))
                            cnt_q <= PACC_CYC[15:0] + 16'h0003;
                        else if (selectN_q)
                            cnt_q <= (CE_CYC[15:0] > ACC_CYC[15:0] ? CE_CYC[15:0] : ACC_CYC[15:0]) + 16'h0003;
                        else
                            cnt_q <= ACC_CYC[15:0] + 16'h0003;
                        lastPage_q <= pageOf(addr, wordMode);
                        pageValid_q <= 1'b1;
                        state_q <= ST_READ;
                    end else if (cmdGo && cmdCode == `FBM_CMD_WRITE) begin
                        if (bufFull) begin
                            bufErr_q <= 1'b1;
                        end else begin
                            if (bufMode)
                                bufCnt_q <= bufCnt_q + 6'h01;
                            flashAddr_q <= pinAddr(addr, wordMode);
                            selectN_q <= 1'b0;
                            outEnN_q <= 1'b1;
                            pageValid_q <= 1'b0;
                            dqOut_q <= wordMode ? wdat : {addr[0], 7'h00, wdat[7:0]};
                            dqOe_b_q <= wordMode ? 16'h0000 : 16'h7f00;
                            state_q <= ST_WSETUP;
                        end
                    end else if (cmdGo && cmdCode == `FBM_CMD_CLEAR && !boostReq) begin
                        clearN_q <= 1'b0;
                        selectN_q <= 1'b1;
                        outEnN_q <= 1'b1;
                        dqOe_b_q <= 16'hffff;
                        pageValid_q <= 1'b0;
                        cnt_q <= RP_CYC[15:0];
                        state_q <= ST_CLEAR;
                    end else if (cmdGo) begin
                        refused_q <= 1'b1;
                    end
                end
                ST_READ: begin
                    if (cnt_q <= 16'h0001) begin
                        rdat_q <= wordMode ? dqSync_q : {8'h00, dqSync_q[7:0]};
                        outEnN_q <= 1'b1;
                        // Dropping select after each read means the next one waits the full time
                        if (!ctrl[`FBM_CTRL_HOLD]) begin
                            selectN_q <= 1'b1;
                            pageValid_q <= 1'b0;
                        end
                        state_q <= ST_IDLE;
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_WSETUP: begin
                    writeN_q <= 1'b0;
                    cnt_q <= WP_CYC[15:0];
                    state_q <= ST_WPULSE;
                end
                ST_WPULSE: begin
                    if (cnt_q <= 16'h0001) begin
                        writeN_q <= 1'b1;
                        state_q <= ST_WHOLD;
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_WHOLD: begin
                    // Select may drop while the flash programs or erases on its own
                    selectN_q <= 1'b1;
                    dqOe_b_q <= 16'hffff;
                    state_q <= ST_IDLE;
                end
                ST_CLEAR: begin
                    if (cnt_q <= 16'h0001) begin
                        clearN_q <= 1'b1;
                        cnt_q <= RH_CYC[15:0];
                        state_q <= ST_RECOVER;
                    end else
                        cnt_q <= cnt_q - 16'h0001;
                end
                ST_RECOVER: begin
                    // Flash is back in read-array mode after this wait
                    if (cnt_q <= 16'h0001)
                        state_q <= ST_IDLE;
                    else
                        cnt_q <= cnt_q - 16'h0001;
                end
                default: state_q <= ST_IDLE;
            endcase
            if (cmdGo && busy)
                refused_q <= 1'b1;
        end
    end
endmodule

//--- hw/fbm_defines.vh
`ifndef FBM_DEFINES_VH
`define FBM_DEFINES_VH

`define FBM_REG_CTRL 8'h00
`define FBM_REG_ADDR 8'h04
`define FBM_REG_WDATA 8'h08
`define FBM_REG_CMD 8'h0c
`define FBM_REG_STATUS 8'h10
`define FBM_REG_RDATA 8'h14

`define FBM_CTRL_WORD 0
`define FBM_CTRL_BOOST 1
`define FBM_CTRL_HOLD 2
`define FBM_CTRL_BUF 3
`define FBM_CTRL_PROT 4
`define FBM_CTRL_RESET 5'h11

`define FBM_CMD_READ 2'h1
`define FBM_CMD_WRITE 2'h2
`define FBM_CMD_CLEAR 2'h3

`define FBM_ST_BUSY 0
`define FBM_ST_REFUSED 1
`define FBM_ST_BUFERR 2

`define FBM_BUF_WORDS 16
`define FBM_BUF_BYTES 32

`define FBM_CLK_NS 10
`define FBM_RANDOM_ACCESS_NS 100
`define FBM_PAGE_ACCESS_NS 30
`define FBM_SELECT_ACCESS_NS 100
`define FBM_WRITE_PULSE_NS 50
`define FBM_CLEAR_PULSE_NS 500
`define FBM_CLEAR_RECOVER_NS 200
`define FBM_CYC_MIN(ns) (((ns) + `FBM_CLK_NS - 1) / `FBM_CLK_NS)
`define FBM_ACC_CYC `FBM_CYC_MIN(`FBM_RANDOM_ACCESS_NS)
`define FBM_PACC_CYC `FBM_CYC_MIN(`FBM_PAGE_ACCESS_NS)
`define FBM_CE_CYC `FBM_CYC_MIN(`FBM_SELECT_ACCESS_NS)
`define FBM_WP_CYC `FBM_CYC_MIN(`FBM_WRITE_PULSE_NS)
`define FBM_RP_CYC `FBM_CYC_MIN(`FBM_CLEAR_PULSE_NS)
`define FBM_RH_CYC `FBM_CYC_MIN(`FBM_CLEAR_RECOVER_NS)

`endif

//--- test/fbm_ctrl_assertions.sv
`timescale 1ns/1ps
module fbm_ctrl_assertions #(
    parameter integer PACC_CYC = 2,
    parameter integer WP_CYC = 2,
    parameter integer RP_CYC = 3
) (
    input wire clk, // Clock
    input wire rst_b, // Reset, low
    input wire [21:0] flashAddr_q, // Address
    input wire [15:0] dqOe_b_q, // Enables
    input wire selectN_q, // Select
    input wire outEnN_q, // Read strobe
    input wire writeN_q, // Write strobe
    input wire clearN_q, // Clear
    input wire wordSel_q, // Width
    input wire boostEn_q // Boost
);
    reg [7:0] wrLow_q, clrLow_q, rdLow_q;
    // Low-time counters
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrLow_q <= 8'h00;
            clrLow_q <= 8'h00;
            rdLow_q <= 8'h00;
        end else begin
            wrLow_q <= writeN_q ? 8'h00 : wrLow_q + 8'h01;
            clrLow_q <= clearN_q ? 8'h00 : clrLow_q + 8'h01;
            rdLow_q <= outEnN_q ? 8'h00 : rdLow_q + 8'h01;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_read_shape: assert property (!outEnN_q |-> writeN_q && !selectN_q)
        else $error("read strobe without select");
    a_write_shape: assert property (!writeN_q |-> !selectN_q && outEnN_q)
        else $error("write strobe with bad levels");
    a_write_width: assert property ($rose(writeN_q) |-> wrLow_q == WP_CYC)
        else $error("write pulse width wrong");
    a_select_leads: assert property ($fell(writeN_q) |-> !$past(selectN_q))
        else $error("select not ahead of write strobe");
    a_word_float: assert property (!outEnN_q && wordSel_q |-> dqOe_b_q == 16'hffff)
        else $error("host drives data during word read");
    a_byte_lanes: assert property (!outEnN_q && !wordSel_q |-> dqOe_b_q == 16'h7fff)
        else $error("byte read lanes wrong");
    a_byte_float: assert property (!wordSel_q |-> &dqOe_b_q[14:8])
        else $error("upper byte lanes driven in byte mode");
    a_clear_width: assert property ($rose(clearN_q) |-> clrLow_q == RP_CYC)
        else $error("clear pulse width wrong");
    a_clear_quiet: assert property (!clearN_q |-> selectN_q && writeN_q)
        else $error("access during clear");
    a_boost_prog: assert property (boostEn_q |-> outEnN_q)
        else $error("read while boosted");
    a_read_wait: assert property ($rose(outEnN_q) |-> rdLow_q >= PACC_CYC)
        else $error("read strobe too short");
    a_addr_hold: assert property (!outEnN_q && !$past(outEnN_q) |-> $stable(flashAddr_q))
        else $error("address moved during read");
    c_clear: cover property ($rose(clearN_q));
    c_byte_write: cover property ($rose(writeN_q) && !wordSel_q);
    c_page_hold: cover property ($rose(outEnN_q) && !selectN_q);
endmodule

//--- test/fbm_ctrl_tb_top.sv
`timescale 1ns/1ps
module fbm_ctrl_tb_top;
    localparam PACC_CYC = 2;
    localparam WP_CYC = 2;
    localparam RP_CYC = 3;
    reg clk = 1'b0;
    reg rst_b = 1'b0;
    reg [7:0] awaddr = 8'h00;
    reg [7:0] araddr = 8'h00;
    reg [31:0] wdata = 32'h0;
    reg [3:0] wstrb = 4'h0;
    reg awvalid = 1'b0;
    reg wvalid = 1'b0;
    reg bready = 1'b0;
    reg arvalid = 1'b0;
    reg rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [21:0] flashAddr;
    wire [15:0] dqIn, dqOut, dqOe_b;
    wire selectN, outEnN, writeN, clearN, wordSel, protLevel, boostEn;
    integer seed = 32'ha569;
    integer miscompares = 0;
    integer testsRun = 0;
    integer i, k;
    reg [31:0] d, a;
    reg [1:0] r;
    reg w;
    fbm_ctrl #(.ACC_CYC(3), .PACC_CYC(PACC_CYC), .CE_CYC(3), .WP_CYC(WP_CYC), .RP_CYC(RP_CYC), .RH_CYC(2)) i_fbm_ctrl (
        .clk(clk), .rst_b(rst_b), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .flashAddr_q(flashAddr), .dqIn(dqIn), .dqOut_q(dqOut), .dqOe_b_q(dqOe_b),
        .selectN_q(selectN), .outEnN_q(outEnN), .writeN_q(writeN), .clearN_q(clearN), .wordSel_q(wordSel),
        .protLevel_q(protLevel), .boostEn_q(boostEn));
    fbm_flash_model #(.ACC_CYC(4'h3), .PACC_CYC(4'h2)) i_fbm_flash_model (
        .clk(clk), .flashAddr(flashAddr), .dqOut(dqOut), .dqOe_b(dqOe_b), .selectN(selectN),
        .outEnN(outEnN), .writeN(writeN), .clearN(clearN), .wordSel(wordSel), .dqIn(dqIn));
    // Clock
    initial begin
        forever #5 clk = ~clk;
    end
    task automatic chk(input [31:0] got, input [31:0] exp);
        begin
            testsRun = testsRun + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // Handshakes are sampled at the rising edge
    task automatic axw(input [7:0] ad, input [31:0] dt, output [1:0] rs);
        reg b;
        begin
            awaddr <= ad;
            wdata <= dt;
            wstrb <= 4'hf;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            b = 1'b0;
            while (!b) begin
                @(posedge clk);
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                b = bvalid;
                rs = bresp;
            end
            bready <= 1'b0;
            @(posedge clk);
        end
    endtask
    task automatic axr(input [7:0] ad, output [31:0] dt, output [1:0] rs);
        reg rv;
        begin
            araddr <= ad;
            arvalid <= 1'b1;
            rready <= 1'b1;
            rv = 1'b0;
            while (!rv) begin
                @(posedge clk);
                if (arready) arvalid <= 1'b0;
                rv = rvalid;
                dt = rdata;
                rs = rresp;
            end
            rready <= 1'b0;
            @(posedge clk);
        end
    endtask
    // Issue a command, then poll busy
    task automatic cmd(input [1:0] c);
        reg [31:0] s;
        begin
            axw(8'h0c, {30'h0, c}, r);
            s = 32'h1;
            while (s[0]) axr(8'h10, s, r);
        end
    endtask
    function automatic [15:0] exp_rd(input [22:0] ad, input wm);
        reg [15:0] v;
        begin
            v = wm ? ad[15:0] ^ {ad[21:16], 10'h1a5} : ad[16:1] ^ {ad[22:17], 10'h1a5};
            exp_rd = wm ? v : {8'h00, ad[0] ? v[15:8] : v[7:0]};
        end
    endfunction
    task automatic rd_chk(input [22:0] ad, input wm);
        begin
            axw(8'h04, {9'h0, ad}, r);
            cmd(2'h1);
            axr(8'h14, d, r);
            chk(d, {16'h0, exp_rd(ad, wm)});
        end
    endtask
    task report_and_stop;
        begin
            $display("Checks %0d, mismatches %0d", testsRun, miscompares);
            if (miscompares == 0 && testsRun > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // Watchdog, well past the run's length
    initial begin
        repeat (30000) @(posedge clk);
        miscompares = miscompares + 1;
        report_and_stop;
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        axr(8'h00, d, r);
        chk(d, 32'h11);
        axr(8'h18, d, r);
        chk(r, 2'h2);
        axw(8'h1c, 32'h5, r);
        chk(r, 2'h2);
        // Random reads in both widths; later ones hold select for page reads
        for (i = 0; i < 24; i = i + 1) begin
            if (i % 3 == 0) w = $random(seed);
            if (i % 3 == 0) a = $random(seed);
            else a[2:0] = $random(seed);
            axw(8'h00, {27'h0, 1'b1, 1'b0, i >= 12, 1'b0, w}, r);
            rd_chk(a[22:0], w);
        end
        // Command writes carry data and byte address to the pins
        for (i = 0; i < 4; i = i + 1) begin
            w = i[0];
            a = $random(seed);
            d = $random(seed);
            axw(8'h00, {27'h0, 1'b1, 3'h0, w}, r);
            axw(8'h04, {9'h0, a[22:0]}, r);
            axw(8'h08, d, r);
            cmd(2'h2);
            chk(i_fbm_flash_model.wrData, w ? d[15:0] : d[7:0]);
            chk(i_fbm_flash_model.wrAddr, w ? {a[21:0], 1'b0} : a[22:0]);
        end
        // Buffered programming refuses the write past its limit
        for (k = 0; k < 2; k = k + 1) begin
            axw(8'h00, {27'h0, 2'h3, 2'h0, ~k[0]}, r);
            for (i = 0; i <= (k ? 32 : 16); i = i + 1) begin
                cmd(2'h2);
                axr(8'h10, d, r);
                chk(d[2], i == (k ? 32 : 16));
            end
            axw(8'h10, 32'h0, r);
            axw(8'h00, 32'h11, r);
            axr(8'h10, d, r);
            chk(d[2:1], 2'h0);
        end
        // Boost: a read is refused, programming still runs
        axw(8'h00, 32'h13, r);
        cmd(2'h1);
        axr(8'h10, d, r);
        chk(d[1], 1'b1);
        axw(8'h10, 32'h0, r);
        cmd(2'h2);
        axr(8'h10, d, r);
        chk(d[1], 1'b0);
        axw(8'h00, 32'h11, r);
        // Clear pulse, then array reads work again
        cmd(2'h3);
        rd_chk(23'h1234, 1'b1);
        report_and_stop;
    end
endmodule
bind fbm_ctrl fbm_ctrl_assertions #(.PACC_CYC(PACC_CYC), .WP_CYC(WP_CYC), .RP_CYC(RP_CYC)) i_fbm_ctrl_assertions (
    .clk(clk), .rst_b(rst_b), .flashAddr_q(flashAddr_q), .dqOe_b_q(dqOe_b_q), .selectN_q(selectN_q),
    .outEnN_q(outEnN_q), .writeN_q(writeN_q), .clearN_q(clearN_q), .wordSel_q(wordSel_q), .boostEn_q(boostEn_q));

//--- test/fbm_flash_model.sv
`timescale 1ns/1ps
module fbm_flash_model #(
    parameter [3:0] ACC_CYC = 4'h3,
    parameter [3:0] PACC_CYC = 4'h2
) (
    input wire clk, // Counts access time and toggles the floating lanes
    input wire [21:0] flashAddr, // Address
    input wire [15:0] dqOut, // Host drive
    input wire [15:0] dqOe_b, // Host enables
    input wire selectN, // Select
    input wire outEnN, // Read strobe
    input wire writeN, // Write strobe
    input wire clearN, // Clear
    input wire wordSel, // Width
    output wire [15:0] dqIn // Wire level
);
    reg [3:0] cnt_q = 4'h0;
    reg [3:0] need_q = 4'h3;
    reg [22:0] last_q = 23'h0;
    reg selPrev_q = 1'b0;
    reg tog_q = 1'b0;
    reg [15:0] wrData;
    reg [22:0] wrAddr;
    // Array content is a fixed function of the address
    wire [22:0] a = {flashAddr, wordSel ? 1'b0 : dqOut[15]};
    wire [15:0] arr = flashAddr[15:0] ^ {flashAddr[21:16], 10'h1a5};
    wire [15:0] val = wordSel ? arr : {8'h00, dqOut[15] ? arr[15:8] : arr[7:0]};
    wire drive = !selectN && !outEnN && writeN && clearN;
    wire [15:0] lanes = !drive ? 16'h0000 : wordSel ? 16'hffff : 16'h00ff;
    // Inverted data until the access time runs out, so early sampling is caught
    wire [15:0] fData = (cnt_q + 1 >= need_q) ? val : ~val;
    // Floating lanes toggle so a host never reads a lucky value
    assign dqIn = (~dqOe_b & dqOut) | (dqOe_b & lanes & fData) | (dqOe_b & ~lanes & {16{tog_q}});
    // Access timer: full time after select, page time inside a held page
    always @(posedge clk) begin
        tog_q <= ~tog_q;
        last_q <= a;
        selPrev_q <= !selectN;
        if (selectN || !clearN) begin
            cnt_q <= 4'h0;
            need_q <= ACC_CYC;
        end else if (a != last_q) begin
            cnt_q <= 4'h0;
            need_q <= (selPrev_q && a[22:3] == last_q[22:3]) ? PACC_CYC : ACC_CYC;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // Command data latched on the strobe's rising edge
    always @(posedge writeN) begin
        if (!selectN && clearN) begin
            wrData <= wordSel ? dqIn : {8'h00, dqIn[7:0]};
            wrAddr <= a;
        end
    end
endmodule
